// ---- verilog/adc_alert_config_regs.sv ----
// alert status, configuration and threshold register bank
// Functional notes
// - over-range flag sets when a new result exceeds the upper threshold
// - under-range flag sets when a new result is below the lower threshold
// - writing one to a flag bit clears that flag
// - without hold, over flag self-clears below upper minus hysteresis
// - without hold, under flag self-clears above lower plus hysteresis
// - with hold set, flags never self-clear; only writes clear them
// - interval code zero disables automatic mode; power-up value is zero
// - non-zero interval code runs conversions repeatedly without requests
// - interval is conversion period times 32 up to 2048 per code
// - flag-enable bit gates alert bit 15 of the result word
// - pin-enable bit zero leaves the alert pin undriven
// - polarity bit zero gives active low, one gives active high pin
// - reserved status, configuration and lower threshold bits read zero
// - lower threshold is twelve bits in bits 11 to 0
// - a flag reads one from a violating result until it self-clears or a write clears it
// - result bit 15 is one when gating is on and a flag is set
// - upper threshold sits at pointer four, resets to all ones
// - hysteresis margin is twelve bits at pointer five
`timescale 1ns/1ns
`include "adc_alert_params.svh"

module adc_alert_config_regs #(
	parameter int CONV_PERIOD_CYC = `CONV_PERIOD_CYC
) (
	// clock and reset
	input  wire logic                     mclk_in,
	input  wire logic                     rst_in,
	// register access through the pointer
	input  wire logic [2:0]               ptr_in,
	input  wire logic                     wr_en_in,
	input  wire logic [15:0]              wr_data_in,
	output logic      [15:0]              rd_data_out,
	// conversion engine
	input  wire logic                     conv_done_in,
	input  wire adc_alert_pkg::sample_t   conv_result_in,
	output logic                          conv_start_out,
	// alert pin
	output logic                          alert_out,
	output logic                          alert_oe_out
);

	////////////////////////////////////////////////////////////////////////
	// storage

	logic [1:0]              status_reg;
	logic [1:0]              status_next;
	logic [7:0]              config_reg;
	adc_alert_pkg::sample_t  lower_reg;
	adc_alert_pkg::sample_t  upper_reg;
	adc_alert_pkg::sample_t  hyst_reg;
	adc_alert_pkg::sample_t  result_reg;
	logic [15:0]             rd_data_reg;
	logic [15:0]             rd_data_next;
	logic                    alert_reg;
	logic                    alert_next;
	logic                    alert_oe_reg;

	////////////////////////////////////////////////////////////////////////
	// decode

	wire                     wr_status;
	wire                     wr_config;
	wire                     wr_lower;
	wire                     wr_upper;
	wire                     wr_hyst;
	wire                     cfg_hold;
	wire                     cfg_flag_en;
	wire                     cfg_pin_en;
	wire                     cfg_pol;
	adc_alert_pkg::ivl_t     cfg_ivl;
	wire                     any_flag;

	// write strobes per pointer value
	assign wr_status = wr_en_in && ptr_in == `PTR_STATUS;
	assign wr_config = wr_en_in && ptr_in == `PTR_CONFIG;
	assign wr_lower  = wr_en_in && ptr_in == `PTR_LOWER;
	assign wr_upper  = wr_en_in && ptr_in == `PTR_UPPER;
	assign wr_hyst   = wr_en_in && ptr_in == `PTR_HYST;

	// configuration fields
	assign cfg_hold    = config_reg[`CFG_HOLD];
	assign cfg_flag_en = config_reg[`CFG_FLAG_EN];
	assign cfg_pin_en  = config_reg[`CFG_PIN_EN];
	assign cfg_pol     = config_reg[`CFG_POL];
	assign cfg_ivl     = adc_alert_pkg::ivl_t'(
		config_reg[`CFG_IVL_HI:`CFG_IVL_LO]);
	assign any_flag    = |status_reg;

	////////////////////////////////////////////////////////////////////////
	// threshold comparison

	wire signed [12:0]       over_clr_lim;
	wire        [12:0]       under_clr_lim;
	wire signed [12:0]       res_s;
	wire                     over_set;
	wire                     under_set;
	wire                     over_self;
	wire                     under_self;
	wire                     over_w1c;
	wire                     under_w1c;

	// limits widened so a large margin cannot wrap around
	assign res_s         = $signed({1'b0, conv_result_in});
	assign over_clr_lim  = $signed({1'b0, upper_reg}) -
		$signed({1'b0, hyst_reg});
	assign under_clr_lim = {1'b0, lower_reg} + {1'b0, hyst_reg};

	// set on each completed result, strict compares
	assign over_set  = conv_done_in && conv_result_in > upper_reg;
	assign under_set = conv_done_in && conv_result_in < lower_reg;

	// self-clear only while hold is off
	assign over_self  = conv_done_in && !cfg_hold &&
		res_s < over_clr_lim;
	assign under_self = conv_done_in && !cfg_hold &&
		{1'b0, conv_result_in} > under_clr_lim;

	// write-one-to-clear strobes
	assign over_w1c  = wr_status && wr_data_in[`STAT_OVER];
	assign under_w1c = wr_status && wr_data_in[`STAT_UNDER];

	// a new violation wins over any clear in the same cycle
	assign status_next[`STAT_OVER]  = over_set ||
		(status_reg[`STAT_OVER] && !over_w1c && !over_self);
	assign status_next[`STAT_UNDER] = under_set ||
		(status_reg[`STAT_UNDER] && !under_w1c && !under_self);

	////////////////////////////////////////////////////////////////////////
	// read path and pin level

	// read mux; reserved bits fill with zero
	assign rd_data_next =
		ptr_in == `PTR_RESULT ? {cfg_flag_en && any_flag,
			3'h0, result_reg} :
		ptr_in == `PTR_STATUS ? {14'h0000, status_reg} :
		ptr_in == `PTR_CONFIG ? {8'h00,
			config_reg & `CONFIG_WMASK} :
		ptr_in == `PTR_LOWER  ? {4'h0, lower_reg} :
		ptr_in == `PTR_UPPER  ? {4'h0, upper_reg} :
		ptr_in == `PTR_HYST   ? {4'h0, hyst_reg} :
		16'h0000;

	// active level follows polarity; level forced low when pin disabled
	assign alert_next = cfg_pin_en &&
		(cfg_pol ? any_flag : !any_flag);

	////////////////////////////////////////////////////////////////////////
	// register updates

	// alert flags
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			status_reg <= `STATUS_RST;
		end else begin
			status_reg <= status_next;
		end
	end

	// configuration, reserved bit masked off
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			config_reg <= `CONFIG_RST;
		end else if (wr_config) begin
			config_reg <= wr_data_in[7:0] & `CONFIG_WMASK;
		end
	end

	// threshold and margin registers take the low twelve bits
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			lower_reg <= `LOWER_RST;
			upper_reg <= `UPPER_RST;
			hyst_reg  <= `HYST_RST;
		end else begin
			if (wr_lower) begin
				lower_reg <= wr_data_in[`SAMPLE_HI:0];
			end
			if (wr_upper) begin
				upper_reg <= wr_data_in[`SAMPLE_HI:0];
			end
			if (wr_hyst) begin
				hyst_reg <= wr_data_in[`SAMPLE_HI:0];
			end
		end
	end

	// latest conversion result
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			result_reg <= `RESULT_RST;
		end else if (conv_done_in) begin
			result_reg <= conv_result_in;
		end
	end

	// registered read data and alert pin
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_reg  <= 16'h0000;
			alert_reg    <= 1'b0;
			alert_oe_reg <= 1'b0;
		end else begin
			rd_data_reg  <= rd_data_next;
			alert_reg    <= alert_next;
			alert_oe_reg <= cfg_pin_en;
		end
	end

	assign rd_data_out  = rd_data_reg;
	assign alert_out    = alert_reg;
	assign alert_oe_out = alert_oe_reg;

	////////////////////////////////////////////////////////////////////////
	// automatic conversion timer

	// start pulses come from a flop inside the timer
	auto_conv_timer #(
		.CONV_PERIOD_CYC (CONV_PERIOD_CYC)
	) u_timer (
		.mclk_in   (mclk_in),
		.rst_in    (rst_in),
		.ivl_in    (cfg_ivl),
		.start_out (conv_start_out)
	);

	////////////////////////////////////////////////////////////////////////
	// assertions

	property p_over_set;
		@(posedge mclk_in) disable iff (rst_in)
		conv_done_in && conv_result_in > upper_reg |=> status_reg[`STAT_OVER];
	endproperty
	a_over_set: assert property (p_over_set)
		else $error("over flag not set on high result");

	property p_under_set;
		@(posedge mclk_in) disable iff (rst_in)
		conv_done_in && conv_result_in < lower_reg
		|=> status_reg[`STAT_UNDER];
	endproperty
	a_under_set: assert property (p_under_set)
		else $error("under flag not set on low result");

	property p_w1c;
		@(posedge mclk_in) disable iff (rst_in)
		wr_status && wr_data_in[`STAT_OVER] && !over_set
		|=> !status_reg[`STAT_OVER];
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("write one did not clear over flag");

	property p_self_clear_over;
		@(posedge mclk_in) disable iff (rst_in)
		conv_done_in && !cfg_hold && !over_set &&
		$signed({1'b0, conv_result_in}) <
		$signed({1'b0, upper_reg}) - $signed({1'b0, hyst_reg})
		|=> !status_reg[`STAT_OVER];
	endproperty
	a_self_clear_over: assert property (p_self_clear_over)
		else $error("over flag did not self-clear");

	property p_self_clear_under;
		@(posedge mclk_in) disable iff (rst_in)
		conv_done_in && !cfg_hold && !under_set &&
		{1'b0, conv_result_in} > {1'b0, lower_reg} + {1'b0, hyst_reg}
		|=> !status_reg[`STAT_UNDER];
	endproperty
	a_self_clear_under: assert property (p_self_clear_under)
		else $error("under flag did not self-clear");

	property p_hold;
		@(posedge mclk_in) disable iff (rst_in)
		cfg_hold && status_reg[`STAT_OVER] && !over_w1c
		|=> status_reg[`STAT_OVER];
	endproperty
	a_hold: assert property (p_hold)
		else $error("held over flag cleared itself");

	property p_pin_hiz;
		@(posedge mclk_in) disable iff (rst_in)
		!cfg_pin_en ##1 !cfg_pin_en |-> !alert_oe_out && !alert_out;
	endproperty
	a_pin_hiz: assert property (p_pin_hiz)
		else $error("alert pin driven while disabled");

	property p_pin_level;
		@(posedge mclk_in) disable iff (rst_in)
		cfg_pin_en |=> alert_out == ($past(cfg_pol) ? $past(any_flag) :
			!$past(any_flag));
	endproperty
	a_pin_level: assert property (p_pin_level)
		else $error("alert pin level wrong for polarity");

	property p_result_alert;
		@(posedge mclk_in) disable iff (rst_in)
		ptr_in == `PTR_RESULT |=> rd_data_out[`RES_ALERT_BIT] ==
			($past(cfg_flag_en) && $past(any_flag));
	endproperty
	a_result_alert: assert property (p_result_alert)
		else $error("result alert bit mismatch");

	property p_reserved;
		@(posedge mclk_in) disable iff (rst_in)
		ptr_in == `PTR_STATUS |=> rd_data_out[15:2] == 14'h0000;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved status bits read non-zero");

	c_over:   cover property (@(posedge mclk_in) disable iff (rst_in)
		over_set ##1 status_reg[`STAT_OVER]);
	c_under:  cover property (@(posedge mclk_in) disable iff (rst_in)
		under_set ##1 status_reg[`STAT_UNDER]);
	c_self:   cover property (@(posedge mclk_in) disable iff (rst_in)
		status_reg[`STAT_OVER] ##1 over_self ##1 !status_reg[`STAT_OVER]);
	c_pin_hi: cover property (@(posedge mclk_in) disable iff (rst_in)
		alert_oe_out && alert_out && cfg_pol);

endmodule // adc_alert_config_regs

// ---- verilog/adc_alert_params.svh ----
// constants for the alert, configuration and threshold register bank
`ifndef ADC_ALERT_PARAMS_SVH
`define ADC_ALERT_PARAMS_SVH

// register pointer values
`define PTR_RESULT       3'h0
`define PTR_STATUS       3'h1
`define PTR_CONFIG       3'h2
`define PTR_LOWER        3'h3
`define PTR_UPPER        3'h4
`define PTR_HYST         3'h5

// alert status field positions
`define STAT_UNDER       0
`define STAT_OVER        1

// configuration field positions
`define CFG_POL          0
`define CFG_PIN_EN       2
`define CFG_FLAG_EN      3
`define CFG_HOLD         4
`define CFG_IVL_LO       5
`define CFG_IVL_HI       7

// result word alert bit and threshold field width
`define RES_ALERT_BIT    15
`define SAMPLE_HI        11

// reset values and the configuration write mask
`define STATUS_RST       2'h0
`define CONFIG_RST       8'h00
`define CONFIG_WMASK     8'hFD
`define UPPER_RST        12'hFFF
`define LOWER_RST        12'h000
`define HYST_RST         12'h000
`define RESULT_RST       12'h000

// timing: conversion period in ns and the clock period in ns
`define CONV_PERIOD_NS   1000
`define CLK_PERIOD_NS    50
`define CONV_PERIOD_CYC  ((`CONV_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// interval code one multiplies by 32, i.e. shift by code plus four
`define IVL_SHIFT_BASE   4'h4
`define IVL_MAX_MULT     2048
`define IVL_MIN_MULT     32

`endif

// ---- verilog/adc_alert_pkg.sv ----
// types shared by the alert register bank and its interval timer
package adc_alert_pkg;

	// one 12-bit conversion sample
	typedef logic [11:0] sample_t;

	// automatic conversion interval codes
	typedef enum logic [2:0] {
		IVL_OFF  = 3'h0,
		IVL_X32  = 3'h1,
		IVL_X64  = 3'h2,
		IVL_X128 = 3'h3,
		IVL_X256 = 3'h4,
		IVL_X512 = 3'h5,
		IVL_X1K  = 3'h6,
		IVL_X2K  = 3'h7
	} ivl_t;

endpackage

// ---- verilog/auto_conv_timer.sv ----
// automatic conversion interval timer
`timescale 1ns/1ns
`include "adc_alert_params.svh"

module auto_conv_timer #(
	parameter int CONV_PERIOD_CYC = `CONV_PERIOD_CYC
) (
	// clock and reset
	input  wire logic                 mclk_in,
	input  wire logic                 rst_in,
	// interval code from configuration
	input  wire adc_alert_pkg::ivl_t  ivl_in,
	// conversion start pulse
	output logic                      start_out
);

	localparam int CW = $clog2(CONV_PERIOD_CYC * `IVL_MAX_MULT + 1);

	// elaboration check on the period
	if (CONV_PERIOD_CYC < 1) begin : g_bad_period
		$error("conversion period must be at least one cycle");
	end

	logic [CW-1:0]        cnt_reg;
	logic [CW-1:0]        cnt_next;
	adc_alert_pkg::ivl_t  ivl_prev_reg;
	logic                 start_reg;
	logic                 start_next;
	wire                  ivl_on;
	wire                  ivl_changed;

	// interval length in cycles for a non-zero code
	function automatic logic [CW-1:0] interval_cycles(
			input adc_alert_pkg::ivl_t code);
		interval_cycles = CW'(CONV_PERIOD_CYC) << ({1'b0, code} +
			`IVL_SHIFT_BASE);
	endfunction

	// restart on any change to a non-zero code, fire again when the count runs out
	assign ivl_on      = (ivl_in != adc_alert_pkg::IVL_OFF);
	assign ivl_changed = (ivl_in != ivl_prev_reg);
	assign start_next  = ivl_on && (ivl_changed || cnt_reg == '0);
	assign cnt_next    = !ivl_on ? '0 :
		start_next ? interval_cycles(ivl_in) - CW'(1) :
		cnt_reg - CW'(1);

	// counter, code history and start pulse
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_reg      <= '0;
			ivl_prev_reg <= adc_alert_pkg::IVL_OFF;
			start_reg    <= 1'b0;
		end else begin
			cnt_reg      <= cnt_next;
			ivl_prev_reg <= ivl_in;
			start_reg    <= start_next;
		end
	end

	assign start_out = start_reg;

	////////////////////////////////////////////////////////////////////////
	// assertions

	// checker helpers: cycles since the last start, and whether that start
	// belongs to a run whose code has not changed since
	logic [CW-1:0]  chk_gap_reg;
	logic           chk_arm_reg;

	// gap counter saturates; a code change disarms until the next start
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			chk_gap_reg <= '0;
			chk_arm_reg <= 1'b0;
		end else begin
			chk_gap_reg <= start_reg ? CW'(1) :
				(&chk_gap_reg) ? chk_gap_reg : chk_gap_reg + CW'(1);
			chk_arm_reg <= ivl_changed ? 1'b0 :
				start_reg ? 1'b1 : chk_arm_reg;
		end
	end

	// a start lasts one cycle unless the code changes under it
	property p_spacing;
		@(posedge mclk_in) disable iff (rst_in)
		start_reg && !ivl_changed |=> !start_reg;
	endproperty
	a_spacing: assert property (p_spacing)
		else $error("automatic starts spaced too closely");

	property p_off_quiet;
		@(posedge mclk_in) disable iff (rst_in)
		ivl_in == adc_alert_pkg::IVL_OFF |=> !start_reg;
	endproperty
	a_off_quiet: assert property (p_off_quiet)
		else $error("start issued with automatic mode off");

	// within an unchanged run, starts come exactly one interval apart
	property p_interval;
		@(posedge mclk_in) disable iff (rst_in)
		start_reg && chk_arm_reg && !ivl_changed |->
		int'(chk_gap_reg) == CONV_PERIOD_CYC * (`IVL_MIN_MULT <<
			(int'(ivl_in) - int'(adc_alert_pkg::IVL_X32)));
	endproperty
	a_interval: assert property (p_interval)
		else $error("automatic interval not honoured");

	c_auto_start: cover property (@(posedge mclk_in) disable iff (rst_in)
		start_reg ##1 !start_reg [*8]);

endmodule // auto_conv_timer

// ---- verification/bus_ctrl_model.sv ----
// register-port controller and conversion engine stand-in
`timescale 1ns/1ns

module bus_ctrl_model (
	// clock
	input  wire logic                   mclk_in,
	// register port
	output logic      [2:0]             ptr_out,
	output logic                        wr_en_out,
	output logic      [15:0]            wr_data_out,
	input  wire logic [15:0]            rd_data_in,
	// conversion engine
	input  wire logic                   conv_start_in,
	output logic                        conv_done_out,
	output adc_alert_pkg::sample_t      conv_result_out
);
	logic                    man_done;
	logic                    auto_done;
	adc_alert_pkg::sample_t  man_val;
	adc_alert_pkg::sample_t  auto_val;

	////////////////////////////////////////////////////////////////////////
	// idle values at time zero
	initial begin
		ptr_out = 3'h0;
		wr_en_out = 1'b0;
		wr_data_out = 16'h0000;
		man_done = 1'b0;
		man_val = 12'h000;
		auto_val = 12'h000;
		auto_done = 1'b0;
	end

	// automatic start answered one cycle later with the preset sample
	always @(posedge mclk_in) begin
		auto_done <= conv_start_in;
	end
	assign conv_done_out = auto_done | man_done;
	assign conv_result_out = auto_done ? auto_val : man_val;

	// reserved positions forced to zero unless a scenario asks otherwise
	function automatic logic [15:0] legal(input logic [2:0] p,
		input logic [15:0] d);
		case (p)
			3'h1: legal = d & 16'h0003;
			3'h2: legal = d & 16'h00FD;
			default: legal = d & 16'h0FFF;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// one write strobe; data line scrambled once released
	task automatic write_reg(input logic [2:0] p, input logic [15:0] d,
		input bit raw);
		@(posedge mclk_in);
		ptr_out <= p;
		wr_en_out <= 1'b1;
		wr_data_out <= raw ? d : legal(p, d);
		@(posedge mclk_in);
		wr_en_out <= 1'b0;
		wr_data_out <= ~wr_data_out;
	endtask

	// point, let the registered answer land, then take it
	task automatic read_reg(input logic [2:0] p, output logic [15:0] d);
		@(posedge mclk_in);
		ptr_out <= p;
		repeat (2) @(posedge mclk_in);
		#1;
		d = rd_data_in;
	endtask

	// one completed conversion, then time for flags and pin to settle
	task automatic convert(input adc_alert_pkg::sample_t v);
		@(posedge mclk_in);
		man_done <= 1'b1;
		man_val <= v;
		@(posedge mclk_in);
		man_done <= 1'b0;
		man_val <= ~v;
		repeat (2) @(posedge mclk_in);
		#1;
	endtask
endmodule // bus_ctrl_model

// ---- verification/test_adc_alert_config_regs.sv ----
// self-checking bench for the alert register bank
`timescale 1ns/1ns

module test_adc_alert_config_regs;
	localparam int CONV_CYC = 1;
	logic                    mclk_in;
	logic                    rst_in;
	logic [2:0]              ptr;
	logic                    wr_en;
	logic [15:0]             wr_data;
	logic [15:0]             rd_data_out;
	logic                    conv_done;
	adc_alert_pkg::sample_t  conv_result;
	logic                    conv_start_out;
	logic                    alert_out;
	logic                    alert_oe_out;
	int                      n_mismatch;
	int                      checks;
	logic [15:0]             rst_tab [8];

	////////////////////////////////////////////////////////////////////////
	// clock and reset
	initial begin
		mclk_in = 1'b0;
		forever #25 mclk_in = ~mclk_in;
	end
	initial begin
		rst_in = 1'b1;
		repeat (8) @(posedge mclk_in);
		rst_in <= 1'b0;
	end

	adc_alert_config_regs #(.CONV_PERIOD_CYC(CONV_CYC))
		adc_alert_config_regs_inst (.mclk_in(mclk_in), .rst_in(rst_in),
		.ptr_in(ptr), .wr_en_in(wr_en), .wr_data_in(wr_data),
		.rd_data_out(rd_data_out), .conv_done_in(conv_done),
		.conv_result_in(conv_result), .conv_start_out(conv_start_out),
		.alert_out(alert_out), .alert_oe_out(alert_oe_out));

	bus_ctrl_model bus_ctrl_model_inst (.mclk_in(mclk_in), .ptr_out(ptr),
		.wr_en_out(wr_en), .wr_data_out(wr_data),
		.rd_data_in(rd_data_out), .conv_start_in(conv_start_out),
		.conv_done_out(conv_done), .conv_result_out(conv_result));

	////////////////////////////////////////////////////////////////////////
	// comparison, shortcuts and closing
	task automatic check(input string what, input logic [15:0] got,
		input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [2:0] p, input logic [15:0] d);
		bus_ctrl_model_inst.write_reg(p, d, 1'b0);
	endtask
	task automatic rchk(input logic [2:0] p, input logic [15:0] exp);
		logic [15:0] d;
		bus_ctrl_model_inst.read_reg(p, d);
		check($sformatf("register %0d", p), d, exp);
	endtask
	task automatic conv(input adc_alert_pkg::sample_t v);
		bus_ctrl_model_inst.convert(v);
	endtask
	task automatic pin(input logic [15:0] exp);
		check("alert pin oe,level", {14'h0000, alert_oe_out, alert_out}, exp);
	endtask
	// gap in cycles between two automatic starts
	task automatic gap_of(input logic [2:0] code, output int gap);
		int k;
		wr(3'h2, {8'h00, code, 5'h00});
		k = 0;
		do begin
			@(posedge mclk_in);
			#1;
			k++;
		end while (conv_start_out !== 1'b1 && k < 5000);
		gap = 0;
		do begin
			@(posedge mclk_in);
			#1;
			gap++;
		end while (conv_start_out !== 1'b1 && gap < 5000);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// watchdog, well beyond the expected run of about 4600 cycles
	initial begin
		#(30000 * 50);
		n_mismatch++;
		wrap_up();
	end

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		int gap;
		int cnt;
		n_mismatch = 0;
		checks = 0;
		rst_tab = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
			16'h0FFF, 16'h0000, 16'h0000, 16'h0000};
		@(negedge rst_in);
		pin(16'h0000);
		for (int p = 0; p < 8; p++) begin
			rchk(p[2:0], rst_tab[p]);
		end
		$display("test reset values done");
		bus_ctrl_model_inst.write_reg(3'h2, 16'hFFFF, 1'b1);
		rchk(3'h2, 16'h00FD);
		wr(3'h2, 16'h0000);
		bus_ctrl_model_inst.write_reg(3'h3, 16'hFFFF, 1'b1);
		rchk(3'h3, 16'h0FFF);
		bus_ctrl_model_inst.write_reg(3'h5, 16'hF123, 1'b1);
		rchk(3'h5, 16'h0123);
		bus_ctrl_model_inst.write_reg(3'h1, 16'hFFFF, 1'b1);
		rchk(3'h1, 16'h0000);
		bus_ctrl_model_inst.write_reg(3'h0, 16'h1234, 1'b1);
		rchk(3'h0, 16'h0000);
		$display("test reserved bits done");
		wr(3'h4, 16'h0800);
		wr(3'h3, 16'h0100);
		wr(3'h5, 16'h0010);
		wr(3'h2, 16'h000D);
		conv(12'h800);
		rchk(3'h1, 16'h0000);
		conv(12'h801);
		rchk(3'h1, 16'h0002);
		pin(16'h0003);
		rchk(3'h0, 16'h8801);
		conv(12'h7F0);
		rchk(3'h1, 16'h0002);
		conv(12'h7EF);
		rchk(3'h1, 16'h0000);
		pin(16'h0002);
		conv(12'h100);
		rchk(3'h1, 16'h0000);
		conv(12'h0FF);
		rchk(3'h1, 16'h0001);
		conv(12'h110);
		rchk(3'h1, 16'h0001);
		conv(12'h111);
		rchk(3'h1, 16'h0000);
		$display("test threshold flags done");
		wr(3'h2, 16'h0004);
		conv(12'h0FF);
		pin(16'h0002);
		rchk(3'h0, 16'h00FF);
		wr(3'h1, 16'h0002);
		rchk(3'h1, 16'h0001);
		wr(3'h1, 16'h0001);
		rchk(3'h1, 16'h0000);
		pin(16'h0003);
		$display("test polarity and clearing done");
		wr(3'h2, 16'h0010);
		conv(12'h801);
		conv(12'h000);
		conv(12'h500);
		rchk(3'h1, 16'h0003);
		wr(3'h1, 16'h0003);
		rchk(3'h1, 16'h0000);
		wr(3'h2, 16'h0001);
		conv(12'h801);
		pin(16'h0000);
		wr(3'h1, 16'h0002);
		$display("test hold and pin disable done");
		bus_ctrl_model_inst.auto_val = 12'h801;
		for (int c = 1; c < 8; c++) begin
			gap_of(c[2:0], gap);
			check("gap", gap[15:0], 16'(CONV_CYC * 32 << (c - 1)));
		end
		rchk(3'h1, 16'h0002);
		wr(3'h2, 16'h0000);
		cnt = 0;
		repeat (300) begin
			@(posedge mclk_in);
			#1;
			if (conv_start_out !== 1'b0)
				cnt++;
		end
		check("starts with code zero", cnt[15:0], 16'h0000);
		$display("test automatic interval done");
		wrap_up();
	end
endmodule // test_adc_alert_config_regs
